// *** mts_pkg.sv ***
package mts_pkg;

    // Counter widths and channel counts.
    localparam int MTS_RTC_W = 70;
    localparam int MTS_RTC_CH = 3;
    localparam int MTS_GPT_UNITS = 4;
    localparam int MTS_GPT_W = 32;
    localparam int MTS_RAT_W = 32;
    localparam int MTS_RAT_CH = 2;

    // Real-time count is fixed point: 32 integer seconds over 38 fraction bits.
    localparam int MTS_RTC_FRAC = 38;
    localparam logic [31:0] MTS_RTC_INC_NOM = 32'h00800000;

    // Rates in kHz, MTS_RAT_HZ in Hz; ticks come from a fractional accumulator on the system clock.
    localparam logic [19:0] MTS_SYS_KHZ = 20'h186A0;
    localparam logic [19:0] MTS_GPT_KHZ = 20'h0BB80;
    localparam logic [19:0] MTS_WDT_KHZ = 20'h005DC;
    localparam logic [19:0] MTS_RAT_KHZ = 20'h00FA0;
    localparam logic [21:0] MTS_RAT_HZ = 22'h3D0900;

    // Power modes.
    localparam logic [1:0] MTS_PM_ACTIVE = 2'h0;
    localparam logic [1:0] MTS_PM_IDLE = 2'h1;
    localparam logic [1:0] MTS_PM_STANDBY = 2'h2;
    localparam logic [1:0] MTS_PM_SHUTDOWN = 2'h3;

    // General timer modes.
    localparam logic [2:0] MTS_GPT_ONESHOT = 3'h0;
    localparam logic [2:0] MTS_GPT_PERIODIC = 3'h1;
    localparam logic [2:0] MTS_GPT_PWM = 3'h2;
    localparam logic [2:0] MTS_GPT_EDGE_TIME = 3'h3;
    localparam logic [2:0] MTS_GPT_EDGE_COUNT = 3'h4;

    typedef enum logic [1:0] {
        WD_IDLE,
        WD_RUN,
        WD_WARN,
        WD_BITE
    } mts_wdt_state_t;

endpackage

// *** mts_gpt_if.sv ***
`timescale 1ns/1ns
interface mts_gpt_if;
    logic ce;
    logic tick;
    logic run;
    logic en;
    logic wide;
    logic evIn;
    logic [2:0] mode;
    logic [31:0] load;
    logic [31:0] match;
    logic [31:0] capt;
    logic evOut;
    logic pwm;
    modport ctl (output ce, tick, run, en, wide, evIn, mode, load, match,
                 input capt, evOut, pwm);
    modport tmr (input ce, tick, run, en, wide, evIn, mode, load, match,
                 output capt, evOut, pwm);
endinterface

// *** mts_gp_timer.sv ***
`timescale 1ns/1ns
module mts_gp_timer (
    input wire logic clk_sys,
    input wire logic reset,
    mts_gpt_if.tmr t
);
    logic [31:0] cnt_r, cnt_nxt, capt_r, capt_nxt, mask, lim, cntInc;
    logic done_r, done_nxt, prevIn_r, evOut_r, pwm_r, hit, edgeIn, upd;

    assign mask = t.wide ? 32'hFFFFFFFF : 32'h0000FFFF;
    assign lim = t.match & mask;
    assign cntInc = (cnt_r + 32'h00000001) & mask;
    assign edgeIn = t.evIn & ~prevIn_r;
    // Power gating: outside active and idle the unit holds its state but clears its event pulse.
    assign upd = t.ce & t.run;
    assign t.capt = capt_r;
    assign t.evOut = evOut_r;
    assign t.pwm = pwm_r;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        cnt_nxt = cnt_r;
        capt_nxt = capt_r;
        done_nxt = done_r;
        hit = 1'b0;
        if (!t.en) begin
            cnt_nxt = (t.mode >= mts_pkg::MTS_GPT_EDGE_TIME) ? 32'h00000000 : t.load & mask;
            done_nxt = 1'b0;
        end else begin
            case (t.mode)
                mts_pkg::MTS_GPT_ONESHOT: begin
                    if (t.tick && !done_r) begin
                        if (cnt_r == 32'h00000000) begin
                            hit = 1'b1;
                            done_nxt = 1'b1;
                        end else begin
                            cnt_nxt = cnt_r - 32'h00000001;
                        end
                    end
                end
                mts_pkg::MTS_GPT_PERIODIC, mts_pkg::MTS_GPT_PWM: begin
                    if (t.tick) begin
                        if (cnt_r == 32'h00000000) begin
                            hit = 1'b1;
                            cnt_nxt = t.load & mask;
                        end else begin
                            cnt_nxt = cnt_r - 32'h00000001;
                        end
                    end
                end
                mts_pkg::MTS_GPT_EDGE_TIME: begin
                    if (t.tick) begin
                        cnt_nxt = cntInc;
                    end
                    if (edgeIn) begin
                        capt_nxt = cnt_r;
                        hit = 1'b1;
                    end
                end
                mts_pkg::MTS_GPT_EDGE_COUNT: begin
                    if (edgeIn) begin
                        cnt_nxt = cntInc;
                        hit = (cntInc == lim);
                    end
                end
                default: begin
                    cnt_nxt = cnt_r;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cnt_r <= 32'h00000000;
            capt_r <= 32'h00000000;
            done_r <= 1'b0;
            prevIn_r <= 1'b0;
            evOut_r <= 1'b0;
            pwm_r <= 1'b0;
        end else if (t.ce) begin
            // A gated unit must not leave its event pulse high, or it would keep waking the core.
            evOut_r <= upd && hit;
            if (upd) begin
                cnt_r <= cnt_nxt;
                capt_r <= capt_nxt;
                done_r <= done_nxt;
                prevIn_r <= t.evIn;
                pwm_r <= t.en && t.mode == mts_pkg::MTS_GPT_PWM && cnt_r <= lim;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    a_gpt_power_hold: assert property (@(posedge clk_sys) disable iff (reset)
        !t.run |=> $stable(cnt_r) && $stable(capt_r)) else $error("timer moved while gated");

endmodule // mts_gp_timer

// *** mts_timer_subsystem.sv ***
`timescale 1ns/1ns
module mts_timer_subsystem (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic ce,
    input wire logic [1:0] powerMode,
    input wire logic debugHalt,
    input wire logic lowFreqClk,
    input wire logic [31:0] rtcIncrement,
    input wire logic [15:0] rtcCalib,
    input wire logic rtcHaltOnDebug,
    input wire logic [2:0][69:0] rtcCompare,
    output logic [69:0] rtcCount,
    output logic [2:0] rtcEvent,
    input wire logic [3:0] gptWide,
    input wire logic [7:0] gptEnable,
    input wire logic [7:0][2:0] gptMode,
    input wire logic [7:0][31:0] gptLoad,
    input wire logic [7:0][31:0] gptMatch,
    input wire logic [7:0] gptEventIn,
    output logic [7:0] gptEventOut,
    output logic [7:0] gptPwm,
    output logic [7:0][31:0] gptCapture,
    input wire logic radioOn,
    input wire logic [1:0][31:0] ratCompare,
    output logic [31:0] ratCount,
    output logic [1:0] ratEvent,
    input wire logic wdtEnable,
    input wire logic wdtService,
    input wire logic [31:0] wdtTimeout,
    output logic wdtIrq,
    output logic wdtReset,
    output logic wakeReq
);

    // Fractional rate divider: returns {tick, next accumulator}.
    function automatic logic [20:0] fracStep(input logic [19:0] acc, input logic [19:0] num);
        logic [19:0] sum;
        sum = acc + num;
        if (sum >= mts_pkg::MTS_SYS_KHZ) begin
            fracStep = {1'b1, sum - mts_pkg::MTS_SYS_KHZ};
        end else begin
            fracStep = {1'b0, sum};
        end
    endfunction

    // Real-time count in 4 MHz radio ticks.
    function automatic logic [31:0] ratFromRtc(input logic [69:0] r);
        logic [75:0] p;
        p = 76'(r[69:16]) * 76'(mts_pkg::MTS_RAT_HZ);
        ratFromRtc = p[53:22];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers. The slow clock is sampled, not used as a clock.
    logic lfS1_r, lfS2_r, lfPrev_r, dbgS1_r, dbgS2_r;
    logic [7:0] evS1_r, evS2_r;
    logic lfTick, dbgHalt;
    assign lfTick = lfS2_r & ~lfPrev_r;
    assign dbgHalt = dbgS2_r;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            lfS1_r <= 1'b0;
            lfS2_r <= 1'b0;
            lfPrev_r <= 1'b0;
            dbgS1_r <= 1'b0;
            dbgS2_r <= 1'b0;
            evS1_r <= 8'h00;
            evS2_r <= 8'h00;
        end else if (ce) begin
            lfS1_r <= lowFreqClk;
            lfS2_r <= lfS1_r;
            lfPrev_r <= lfS2_r;
            dbgS1_r <= debugHalt;
            dbgS2_r <= dbgS1_r;
            evS1_r <= gptEventIn;
            evS2_r <= evS1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Rate ticks.
    logic [19:0] gpAcc_r, wdAcc_r, raAcc_r;
    logic [20:0] gpStep, wdStep, raStep;
    assign gpStep = fracStep(gpAcc_r, mts_pkg::MTS_GPT_KHZ);
    assign wdStep = fracStep(wdAcc_r, mts_pkg::MTS_WDT_KHZ);
    assign raStep = fracStep(raAcc_r, mts_pkg::MTS_RAT_KHZ);

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            gpAcc_r <= 20'h00000;
            wdAcc_r <= 20'h00000;
            raAcc_r <= 20'h00000;
        end else if (ce) begin
            gpAcc_r <= gpStep[19:0];
            wdAcc_r <= wdStep[19:0];
            raAcc_r <= raStep[19:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Real-time counter.
    logic [69:0] rtc_r, rtcStepSum, rtc_nxt;
    logic [2:0] rtcEv_r;
    logic rtcHold, rtcAdv;
    // Calibration is signed so it can both slow and speed the count.
    assign rtcStepSum = 70'(rtcIncrement) + {{54{rtcCalib[15]}}, rtcCalib};
    // Standby keeps it running; a halt by the debugger stops it by default.
    assign rtcHold = powerMode == mts_pkg::MTS_PM_SHUTDOWN || (dbgHalt && rtcHaltOnDebug);
    assign rtcAdv = ce && lfTick && !rtcHold;
    assign rtc_nxt = rtc_r + rtcStepSum;
    assign rtcCount = rtc_r;
    assign rtcEvent = rtcEv_r;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rtc_r <= 70'h0;
            rtcEv_r <= 3'h0;
        end else if (ce) begin
            if (rtcAdv) begin
                rtc_r <= rtc_nxt;
            end
            for (int i = 0; i < mts_pkg::MTS_RTC_CH; i++) begin
                rtcEv_r[i] <= rtcAdv && rtc_nxt == rtcCompare[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // General timer units: half A is 32 or 16 bits, half B is 16 bits and enabled only when split.
    logic gpRun;
    assign gpRun = powerMode == mts_pkg::MTS_PM_ACTIVE || powerMode == mts_pkg::MTS_PM_IDLE;

    for (genvar g = 0; g < 8; g++) begin : gGpt
        mts_gpt_if gi ();
        assign gi.ce = ce;
        assign gi.tick = gpStep[20];
        assign gi.run = gpRun;
        assign gi.wide = (g % 2 == 0) ? gptWide[g / 2] : 1'b0;
        assign gi.en = gptEnable[g] && ((g % 2 == 0) || !gptWide[g / 2]);
        assign gi.evIn = evS2_r[g];
        assign gi.mode = gptMode[g];
        assign gi.load = gptLoad[g];
        assign gi.match = gptMatch[g];
        assign gptEventOut[g] = gi.evOut;
        assign gptPwm[g] = gi.pwm;
        assign gptCapture[g] = gi.capt;
        mts_gp_timer uTmr (
            .clk_sys(clk_sys),
            .reset(reset),
            .t(gi.tmr)
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Radio timer.
    logic [31:0] rat_r;
    logic [1:0] ratEv_r;
    logic radioPrev_r, radioFlip, ratAdv;
    logic [31:0] ratSync;
    assign radioFlip = radioOn != radioPrev_r;
    assign ratSync = ratFromRtc(rtc_r);
    assign ratAdv = radioOn && raStep[20];
    assign ratCount = rat_r;
    assign ratEvent = ratEv_r;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rat_r <= 32'h00000000;
            ratEv_r <= 2'h0;
            radioPrev_r <= 1'b0;
        end else if (ce) begin
            radioPrev_r <= radioOn;
            if (radioFlip) begin
                rat_r <= ratSync;
            end else if (ratAdv) begin
                rat_r <= rat_r + 32'h00000001;
            end
            for (int i = 0; i < mts_pkg::MTS_RAT_CH; i++) begin
                ratEv_r[i] <= ratAdv && !radioFlip && rat_r + 32'h00000001 == ratCompare[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Watchdog. Expiry is checked before service so a late service never hides it.
    mts_pkg::mts_wdt_state_t wdSt_r, wdSt_nxt;
    logic [31:0] wdCnt_r, wdCnt_nxt;
    logic wdIrq_r, wdIrq_nxt, wdRst_r, wdFreeze, wdExpire, wdLive;
    assign wdFreeze = powerMode == mts_pkg::MTS_PM_STANDBY || dbgHalt;
    assign wdLive = wdSt_r == mts_pkg::WD_RUN || wdSt_r == mts_pkg::WD_WARN;
    assign wdExpire = wdLive && wdStep[20] && !wdFreeze && wdCnt_r == 32'h00000000;
    assign wdtIrq = wdIrq_r;
    assign wdtReset = wdRst_r;

    always_comb begin
        wdSt_nxt = wdSt_r;
        wdCnt_nxt = wdCnt_r;
        wdIrq_nxt = wdIrq_r;
        case (wdSt_r)
            mts_pkg::WD_IDLE: begin
                if (wdtEnable) begin
                    wdSt_nxt = mts_pkg::WD_RUN;
                    wdCnt_nxt = wdtTimeout;
                end
            end
            mts_pkg::WD_RUN, mts_pkg::WD_WARN: begin
                if (wdExpire) begin
                    wdSt_nxt = (wdSt_r == mts_pkg::WD_RUN) ? mts_pkg::WD_WARN
                        : mts_pkg::WD_BITE;
                    wdIrq_nxt = 1'b1;
                    wdCnt_nxt = wdtTimeout;
                end else if (wdtService) begin
                    wdSt_nxt = mts_pkg::WD_RUN;
                    wdIrq_nxt = 1'b0;
                    wdCnt_nxt = wdtTimeout;
                end else if (wdStep[20] && !wdFreeze) begin
                    wdCnt_nxt = wdCnt_r - 32'h00000001;
                end
            end
            mts_pkg::WD_BITE: begin
                wdSt_nxt = mts_pkg::WD_BITE;
            end
            default: begin
                wdSt_nxt = mts_pkg::WD_IDLE;
            end
        endcase
    end

    // No path leads from the live states back to WD_IDLE except reset.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wdSt_r <= mts_pkg::WD_IDLE;
            wdCnt_r <= 32'h00000000;
            wdIrq_r <= 1'b0;
            wdRst_r <= 1'b0;
        end else if (ce) begin
            wdSt_r <= wdSt_nxt;
            wdCnt_r <= wdCnt_nxt;
            wdIrq_r <= wdIrq_nxt;
            wdRst_r <= wdSt_nxt == mts_pkg::WD_BITE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Wake request out of idle on any timer event.
    logic wake_r;
    assign wakeReq = wake_r;
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wake_r <= 1'b0;
        end else if (ce) begin
            wake_r <= powerMode == mts_pkg::MTS_PM_IDLE &&
                (|gptEventOut || |rtcEv_r || |ratEv_r || wdIrq_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    a_wdt_stays_on: assert property (wdLive |=> wdSt_r != mts_pkg::WD_IDLE)
        else $error("watchdog left live state");
    a_wdt_frozen: assert property (wdLive && wdFreeze && !wdtService |=> $stable(wdCnt_r))
        else $error("watchdog counted while frozen");
    a_wdt_bite_order: assert property ($rose(wdRst_r) |-> $past(wdIrq_r))
        else $error("reset without prior interrupt");
    a_wdt_service_reload: assert property (ce && wdLive && wdtService && !wdExpire
        |=> wdCnt_r == $past(wdtTimeout) && !wdIrq_r) else $error("service did not reload");
    a_wdt_tick_rate: assert property (ce && wdStep[20] |=> !wdStep[20] [*8])
        else $error("watchdog tick too fast");
    a_rtc_hold_stable: assert property (rtcHold |=> $stable(rtc_r))
        else $error("rtc moved while held");
    a_rtc_step_size: assert property (rtcAdv |=> rtc_r == $past(rtc_r) + $past(rtcStepSum))
        else $error("rtc step wrong");
    a_rtc_cmp_event: assert property (rtcAdv && rtc_nxt == rtcCompare[1] |=> rtcEv_r[1])
        else $error("rtc compare event missing");
    a_rat_resync: assert property (ce && radioFlip |=> rat_r == $past(ratSync))
        else $error("radio timer not resynchronised");
    a_gpt_tick_rate: assert property (ce && gpStep[20] |=> !gpStep[20])
        else $error("general tick above 48 MHz");

    c_wdt_bite: cover property (wdSt_r == mts_pkg::WD_WARN ##1 wdRst_r);
    c_rtc_event: cover property (rtcEv_r[2]);
    c_gpt_pwm: cover property ($rose(gptPwm[0]));
    c_rat_resync: cover property (ce && radioFlip && radioOn);

endmodule // mts_timer_subsystem

// *** mts_timer_subsystem_tb.sv ***
`timescale 1ns/1ns
module mts_timer_subsystem_tb;
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin fails++; \
    $display("ERROR t=%0t got %0h exp %0h", $time, (got), (exp)); end end
////////////////////////////////////////////////////////////////////////////////
logic clk_sys = 0, reset = 1, ce = 1, debugHalt = 0, lowFreqClk = 0, rtcHaltOnDebug = 1;
logic radioOn = 0, wdtEnable = 0, wdtService = 0, wdtIrq, wdtReset, wakeReq;
logic [1:0] powerMode = 0;
logic [31:0] rtcIncrement = 32'h00800000, wdtTimeout = 32'h3, ratCount, s;
logic [15:0] rtcCalib = 16'h0;
logic [2:0][69:0] rtcCompare = '1;
logic [69:0] rtcCount, expRtc = 0, prevRtc = 0, expV;
logic [2:0] rtcEvent;
logic [3:0] gptWide = 0;
logic [7:0] gptEnable = 0, gptEventIn = 0, gptEventOut, gptPwm;
logic [7:0][2:0] gptMode = 0;
logic [7:0][31:0] gptLoad = 0, gptMatch = 0, gptCapture;
logic [1:0][31:0] ratCompare = '1;
logic [1:0] ratEvent;
logic [127:0] wideV;
logic [69:0] expQ[$];
int fails = 0, comparisons = 0, cycles = 0, seed = 32'hB130, n, L, pwmHi, wakeHi;
int gEv[8], rEv[3], aEv[2];
////////////////////////////////////////////////////////////////////////////////
initial begin
    forever #5 clk_sys = ~clk_sys;
end
mts_timer_subsystem u_dut (.clk_sys(clk_sys), .reset(reset), .ce(ce), .powerMode(powerMode),
    .debugHalt(debugHalt), .lowFreqClk(lowFreqClk), .rtcIncrement(rtcIncrement),
    .rtcCalib(rtcCalib), .rtcHaltOnDebug(rtcHaltOnDebug), .rtcCompare(rtcCompare),
    .rtcCount(rtcCount), .rtcEvent(rtcEvent), .gptWide(gptWide), .gptEnable(gptEnable),
    .gptMode(gptMode), .gptLoad(gptLoad), .gptMatch(gptMatch), .gptEventIn(gptEventIn),
    .gptEventOut(gptEventOut), .gptPwm(gptPwm), .gptCapture(gptCapture), .radioOn(radioOn),
    .ratCompare(ratCompare), .ratCount(ratCount), .ratEvent(ratEvent), .wdtEnable(wdtEnable),
    .wdtService(wdtService), .wdtTimeout(wdtTimeout), .wdtIrq(wdtIrq), .wdtReset(wdtReset),
    .wakeReq(wakeReq));
////////////////////////////////////////////////////////////////////////////////
task print_verdict();
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
endtask
task cyc(input int k);
    repeat (k) @(posedge clk_sys);
endtask
task clr();
    gEv = '{default: 0}; rEv = '{default: 0}; aEv = '{default: 0}; pwmHi = 0; wakeHi = 0;
endtask
function logic [69:0] step();
    return {38'h0, rtcIncrement} + {{54{rtcCalib[15]}}, rtcCalib};
endfunction
// One slow-clock pulse; when it should count, the new total is noted for the monitor.
task tick(input bit counts);
    @(posedge clk_sys);
    if (counts) begin
        expRtc = expRtc + step();
        expQ.push_back(expRtc);
    end
    lowFreqClk <= 1'b1;
    cyc(8);
    lowFreqClk <= 1'b0;
    cyc(8);
endtask
task doReset();
    @(posedge clk_sys);
    reset <= 1'b1;
    cyc(12);
    reset <= 1'b0;
    expRtc = 0;
    cyc(2);
    #1 `CHK({rtcCount, ratCount, wdtIrq, wdtReset}, 104'h0)
endtask
task waitHi(input bit useReset);
    n = 0;
    while ((useReset ? wdtReset : wdtIrq) !== 1'b1 && n < 700) begin
        @(posedge clk_sys);
        n++;
    end
endtask
////////////////////////////////////////////////////////////////////////////////
// Monitor: any move of the real-time count must match the oldest noted value.
always @(posedge clk_sys) begin
    if (!reset && rtcCount !== prevRtc) begin
        if (expQ.size() == 0) `CHK(rtcCount, prevRtc)
        else begin
            expV = expQ.pop_front();
            `CHK(rtcCount, expV)
        end
    end
    prevRtc = rtcCount;
    for (int i = 0; i < 8; i++) gEv[i] += gptEventOut[i];
    for (int i = 0; i < 3; i++) rEv[i] += rtcEvent[i];
    for (int i = 0; i < 2; i++) aEv[i] += ratEvent[i];
    pwmHi += gptPwm[2];
    wakeHi += wakeReq;
    cycles++;
    if (cycles == 20000) begin
        fails++;
        $display("ERROR t=%0t run did not finish", $time);
        print_verdict();
    end
end
////////////////////////////////////////////////////////////////////////////////
initial begin
    cyc(12);
    reset <= 1'b0;
    cyc(2);
    rtcIncrement <= 32'h00800000 + ($random(seed) & 32'h0000FFFF);
    rtcCalib <= 16'($random(seed));
    rtcCompare[2] <= 70'({$random(seed), $random(seed), $random(seed)});
    ratCompare[1] <= $random(seed);
    repeat (3) tick(1);
    clr();
    rtcCompare[1] <= expRtc + step();
    tick(1);
    `CHK(rEv[1], 1)
    debugHalt <= 1'b1;
    cyc(4);
    tick(0);
    rtcHaltOnDebug <= 1'b0;
    tick(1);
    debugHalt <= 1'b0;
    rtcHaltOnDebug <= 1'b1;
    cyc(4);
    // Standby and idle keep counting, shutdown and a held enable do not.
    powerMode <= mts_pkg::MTS_PM_STANDBY; tick(1);
    powerMode <= mts_pkg::MTS_PM_IDLE; tick(1);
    powerMode <= mts_pkg::MTS_PM_SHUTDOWN; tick(0);
    powerMode <= mts_pkg::MTS_PM_ACTIVE; ce <= 1'b0; tick(0);
    ce <= 1'b1;
    cyc(4);
    `CHK(expQ.size(), 0)
    $display("rtc test done");
    @(posedge clk_sys);
    radioOn <= 1'b1; // The fast clock is taken to run from the crystal here.
    wideV = {58'h0, expRtc >> 16} * 128'd4000000;
    s = 32'(wideV >> 22);
    @(posedge clk_sys);
    #1 `CHK(ratCount, s)
    cyc(250);
    #1 `CHK((ratCount - s) >= 9 && (ratCount - s) <= 11, 1'b1)
    clr();
    ratCompare[0] <= ratCount + 32'h4;
    cyc(200);
    `CHK(aEv[0], 1)
    radioOn <= 1'b0;
    @(posedge clk_sys);
    #1 `CHK(ratCount, s)
    $display("radio test done");
    L = 1 + ($random(seed) & 7);
    gptWide <= 4'h1;
    gptMode[0] <= mts_pkg::MTS_GPT_PERIODIC; gptLoad[0] <= L;
    gptMode[2] <= mts_pkg::MTS_GPT_PWM; gptLoad[2] <= 32'h9; gptMatch[2] <= 32'h4;
    // The upper half of this load must be dropped by a narrow half, or no event comes.
    gptMode[4] <= mts_pkg::MTS_GPT_ONESHOT; gptLoad[4] <= 32'h00010014;
    gptMode[5] <= mts_pkg::MTS_GPT_EDGE_TIME;
    gptMode[6] <= mts_pkg::MTS_GPT_EDGE_COUNT; gptMatch[6] <= 32'h3;
    cyc(2);
    clr();
    gptEnable <= 8'h75;
    cyc(1000);
    `CHK(gEv[0] >= 480 / (L + 1) - 2 && gEv[0] <= 480 / (L + 1) + 2, 1'b1)
    `CHK(gEv[4], 1)
    `CHK(pwmHi > 100 && pwmHi < 900, 1'b1)
    repeat (3) begin
        gptEventIn <= 8'h60;
        cyc(4);
        gptEventIn <= 8'h00;
        cyc(4);
    end
    cyc(4);
    `CHK(gEv[5], 3)
    `CHK(gEv[6], 1)
    `CHK(gptCapture[5] >= 32'h000001DB && gptCapture[5] <= 32'h000001F9, 1'b1)
    powerMode <= mts_pkg::MTS_PM_STANDBY;
    // Let a pulse launched just before the gate drain before counting restarts.
    cyc(2);
    clr();
    cyc(500);
    `CHK(gEv[0], 0)
    powerMode <= mts_pkg::MTS_PM_IDLE;
    cyc(300);
    `CHK(gEv[0] > 0 && wakeHi > 0, 1'b1)
    powerMode <= mts_pkg::MTS_PM_ACTIVE;
    gptEnable <= 8'h00;
    $display("timer test done");
    doReset();
    wdtEnable <= 1'b1;
    cyc(1);
    wdtEnable <= 1'b0;
    waitHi(0);
    `CHK({wdtIrq, wdtReset}, 2'b10)
    `CHK(n >= 190 && n <= 345, 1'b1)
    wdtService <= 1'b1;
    cyc(1);
    wdtService <= 1'b0;
    cyc(2);
    #1 `CHK(wdtIrq, 1'b0)
    powerMode <= mts_pkg::MTS_PM_STANDBY;
    cyc(1500);
    `CHK({wdtIrq, wdtReset}, 2'b00)
    powerMode <= mts_pkg::MTS_PM_ACTIVE;
    waitHi(0);
    `CHK(wdtIrq, 1'b1)
    debugHalt <= 1'b1;
    cyc(1500);
    `CHK(wdtReset, 1'b0)
    debugHalt <= 1'b0;
    waitHi(1);
    cyc(100);
    `CHK(wdtReset, 1'b1)
    doReset();
    cyc(1000);
    `CHK(wdtIrq, 1'b0)
    $display("watchdog test done");
    print_verdict();
end
endmodule // mts_timer_subsystem_tb
